/* File: fnfl_pkg.sv */
// Constants, field layouts and carriers for the fast-lock synthesizer core.
// Assumes a single 20 MHz core clock; serial word is 24 bits, LSB last.
package fnfl_pkg;
    localparam int CLK_MHZ = 20;
    localparam int LD_THR_LO_NS = 3;
    localparam int LD_THR_HI_NS = 10;
    localparam int LD_THR_LO_CYC = (LD_THR_LO_NS * CLK_MHZ / 1000 < 1) ? 1
        : LD_THR_LO_NS * CLK_MHZ / 1000;
    localparam int LD_THR_HI_CYC = (LD_THR_HI_NS * CLK_MHZ / 1000 < 1) ? 1
        : LD_THR_HI_NS * CLK_MHZ / 1000;
    localparam logic [3:0] LD_COUNT = 4'hF;
    localparam int WORD_W = 24;
    localparam logic [2:0] SEL_FREQ = 3'h0;
    localparam logic [2:0] SEL_DIV = 3'h1;
    localparam logic [2:0] SEL_PHASE = 3'h2;
    localparam logic [2:0] SEL_TIMER = 3'h4;
    localparam logic [2:0] SEL_PWR = 3'h5;
    localparam logic [2:0] SEL_MODE = 3'h6;
    localparam logic [1:0] TSEL_PUMP = 2'h2;
    localparam logic [1:0] TSEL_DAMP = 2'h1;
    localparam logic [1:0] TSEL_AUX = 2'h0;
    localparam logic [3:0] MODE_DEFAULT = 4'h0;
    localparam logic [3:0] MODE_DITHER = 4'h3;
    localparam logic [3:0] MODE_LD10 = 4'h9;
    localparam logic [3:0] MUX_LOCK = 4'h1;
    localparam logic [3:0] MUX_REFDIV = 4'h2;
    localparam logic [3:0] MUX_INTDIV = 4'h3;
    localparam logic [3:0] MUX_TIMEOUT = 4'h4;
    localparam logic [6:0] PUMP_MAX = 7'h40;
    localparam logic [6:0] PUMP_UNITY = 7'h01;
    localparam logic [7:0] PWR_RESET = 8'hFD;
    localparam logic [1:0] QUARTER = 2'h3;
    localparam logic [22:0] LFSR_SEED = 23'h000001;

    typedef struct packed {
        logic [7:0] int_val;
        logic [11:0] fractional_numerator;
    } fnfl_freq_s;

    typedef struct packed {
        logic halve;
        logic doubler;
        logic [3:0] rcount;
        logic [11:0] modulus;
    } fnfl_div_s;

    typedef struct packed {
        logic amp_pd;
        logic cp_pd;
        logic tristate;
        logic cnt_reset;
    } fnfl_pwr_s;

    typedef struct packed {
        logic [8:0] aux;
        logic [8:0] damp;
        logic [8:0] pump;
    } fnfl_timers_s;
endpackage

/* File: fnfl_core.sv */
// Digital control core: serial load, fast-lock timers, dividers, modulator.
// Serial clock, data, load strobe, reference and RF feedback arrive as pins
// and are sampled by clk; they must be well below half the clk rate.
module fnfl_core
    import fnfl_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic load_strobe,
    input wire logic reference_input,
    input wire logic rf_feedback,
    output logic aux_filter_switch,
    output logic damping_resistor_switches,
    output logic [6:0] pump_current_scale,
    output logic pump_tristate,
    output logic amp_powerdown,
    output logic ref_buffer_en,
    output logic powered_up,
    output logic lock_detect,
    output logic diagnostic_output_pin,
    output logic [8:0] feedback_ratio
);
    // Stage 0 metastability, stage 1 clean, stage 2 for edge detect
    logic [4:0] sync1_r, sync2_r, sync3_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= {rf_feedback, reference_input, load_strobe,
                        ser_data, ser_clk};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end
    logic sclk_rise, le_rise, ref_rise, ref_fall, rf_rise;
    assign sclk_rise = sync2_r[0] & ~sync3_r[0];
    assign le_rise = sync2_r[2] & ~sync3_r[2];
    assign ref_rise = sync2_r[3] & ~sync3_r[3];
    assign ref_fall = ~sync2_r[3] & sync3_r[3];
    assign rf_rise = sync2_r[4] & ~sync3_r[4];

    // Serial shift register and register decode
    logic [WORD_W-1:0] shift_r;
    always_ff @(posedge clk) begin
        if (srst)
            shift_r <= '0;
        else if (sclk_rise)
            shift_r <= {shift_r[WORD_W-2:0], sync2_r[1]};
    end

    function automatic logic hit(input logic [2:0] code);
        hit = le_rise && (shift_r[2:0] == code);
    endfunction
    logic wr_freq, wr_div, wr_phase, wr_timer, wr_pwr, wr_mode;
    assign wr_freq = hit(SEL_FREQ);
    assign wr_div = hit(SEL_DIV);
    assign wr_phase = hit(SEL_PHASE);
    assign wr_timer = hit(SEL_TIMER);
    assign wr_pwr = hit(SEL_PWR);
    assign wr_mode = hit(SEL_MODE);

    fnfl_freq_s freq_r;
    fnfl_div_s div_buf_r, div_act_r;
    logic [11:0] phase_buf_r, phase_act_r;
    fnfl_timers_s tmr_r;
    logic [7:0] pwr_r;
    logic [3:0] mode_r, mux_sel_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            freq_r <= '0;
            div_buf_r <= '0;
            div_act_r <= '0;
            phase_buf_r <= '0;
            phase_act_r <= '0;
            tmr_r <= '0;
            pwr_r <= PWR_RESET;
            mode_r <= MODE_DEFAULT;
            mux_sel_r <= '0;
        end else begin
            if (wr_freq) begin
                freq_r <= {shift_r[22:15], shift_r[14:3]};
                div_act_r <= div_buf_r;
                phase_act_r <= phase_buf_r;
            end
            if (wr_div)
                div_buf_r <= {shift_r[22], shift_r[20], shift_r[18:15],
                              shift_r[14:3]};
            if (wr_phase)
                phase_buf_r <= shift_r[14:3];
            if (wr_timer) begin
                case (shift_r[4:3])
                    TSEL_PUMP: tmr_r.pump <= shift_r[13:5];
                    TSEL_DAMP: tmr_r.damp <= shift_r[13:5];
                    TSEL_AUX: tmr_r.aux <= shift_r[13:5];
                    default: ;
                endcase
            end
            if (wr_pwr)
                pwr_r <= shift_r[7:0];
            if (wr_mode) begin
                mode_r <= shift_r[15:12];
                mux_sel_r <= shift_r[6:3];
            end
        end
    end

    // Init tracking: seed and setup seen, then frequency with power-down cleared
    logic seen_phase_r, seen_div_r, up_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            seen_phase_r <= 1'b0;
            seen_div_r <= 1'b0;
            up_r <= 1'b0;
        end else begin
            if (wr_phase)
                seen_phase_r <= 1'b1;
            if (wr_div)
                seen_div_r <= 1'b1;
            if (wr_freq && seen_phase_r && seen_div_r && pwr_r[7:3] == '0)
                up_r <= 1'b1;
        end
    end

    fnfl_pwr_s pwr;
    logic hold_div;
    assign pwr.amp_pd = pwr_r[7] & pwr_r[6];
    assign pwr.cp_pd = pwr_r[5] | ~up_r;
    assign pwr.tristate = pwr_r[4];
    assign pwr.cnt_reset = pwr_r[3];
    assign hold_div = pwr.cp_pd | pwr.cnt_reset;

    // Reference divider: doubler counts both edges, halving adds a toggle
    logic [3:0] rcnt_r;
    logic half_r, pfd_tick_r;
    logic ref_edge, rdone;
    assign ref_edge = ref_rise | (div_act_r.doubler & ref_fall);
    assign rdone = ref_edge && (rcnt_r + 4'h1 >= div_act_r.rcount);
    always_ff @(posedge clk) begin
        if (srst || hold_div) begin
            rcnt_r <= '0;
            half_r <= 1'b0;
            pfd_tick_r <= 1'b0;
        end else begin
            pfd_tick_r <= 1'b0;
            if (rdone) begin
                rcnt_r <= '0;
                half_r <= ~half_r;
                pfd_tick_r <= ~div_act_r.halve | half_r;
            end else if (ref_edge) begin
                rcnt_r <= rcnt_r + 4'h1;
            end
        end
    end

    // Third-order MASH modulator at the reference rate
    logic [11:0] acc1_r, acc2_r, acc3_r;
    logic c2d_r, c3d_r, c3dd_r;
    logic [22:0] lfsr_r;
    logic [12:0] s1, s2, s3;
    logic c1, c2, c3;
    logic [11:0] dith;
    logic signed [3:0] sdm_out;
    assign dith = {11'h000, mode_r == MODE_DITHER && lfsr_r[0]};
    assign s1 = {1'b0, acc1_r} + {1'b0, freq_r.fractional_numerator} + {1'b0, dith};
    assign c1 = s1 >= {1'b0, div_act_r.modulus};
    assign s2 = {1'b0, acc2_r} + (c1 ? s1 - {1'b0, div_act_r.modulus} : s1);
    assign c2 = s2 >= {1'b0, div_act_r.modulus};
    assign s3 = {1'b0, acc3_r} + (c2 ? s2 - {1'b0, div_act_r.modulus} : s2);
    assign c3 = s3 >= {1'b0, div_act_r.modulus};
    // Noise-shaped sum c1 + (1-z)c2 + (1-z)^2 c3, range -3..+4
    assign sdm_out = 4'(c1) + 4'(c2) - 4'(c2d_r) + 4'(c3)
        - 4'({c3d_r, 1'b0}) + 4'(c3dd_r);
    logic start_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            acc1_r <= '0;
            acc2_r <= '0;
            acc3_r <= '0;
            {c2d_r, c3d_r, c3dd_r} <= '0;
            lfsr_r <= LFSR_SEED;
        end else if (start_r) begin
            acc1_r <= phase_act_r; // Seed fixes the repeat phase
            acc2_r <= '0;
            acc3_r <= '0;
            {c2d_r, c3d_r, c3dd_r} <= '0;
        end else if (pfd_tick_r) begin
            acc1_r <= c1 ? 12'(s1 - {1'b0, div_act_r.modulus}) : s1[11:0];
            acc2_r <= c2 ? 12'(s2 - {1'b0, div_act_r.modulus}) : s2[11:0];
            acc3_r <= c3 ? 12'(s3 - {1'b0, div_act_r.modulus}) : s3[11:0];
            c2d_r <= c2;
            c3d_r <= c3;
            c3dd_r <= c3d_r;
            lfsr_r <= {lfsr_r[21:0], lfsr_r[22] ^ lfsr_r[17]};
        end
    end

    // Feedback divider; new word takes effect on next reference cycle
    logic [8:0] ncnt_r, nval_r;
    logic fb_tick_r, ref_out_r, int_out_r;
    always_ff @(posedge clk) begin
        if (srst)
            nval_r <= '0;
        else if (pfd_tick_r)
            nval_r <= 9'({1'b0, freq_r.int_val} + 9'(signed'(sdm_out)));
    end
    always_ff @(posedge clk) begin
        if (srst || hold_div) begin
            ncnt_r <= '0;
            fb_tick_r <= 1'b0;
        end else begin
            fb_tick_r <= 1'b0;
            if (rf_rise) begin
                if (ncnt_r + 9'h001 >= nval_r) begin
                    ncnt_r <= '0;
                    fb_tick_r <= 1'b1;
                end else begin
                    ncnt_r <= ncnt_r + 9'h001;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            ref_out_r <= 1'b0;
            int_out_r <= 1'b0;
        end else begin
            if (pfd_tick_r)
                ref_out_r <= ~ref_out_r;
            if (fb_tick_r)
                int_out_r <= ~int_out_r;
        end
    end

    // Fast-lock timers, ticking at a quarter of the reference rate
    logic [1:0] qdiv_r;
    logic [8:0] aux_cnt_r, damp_cnt_r, pump_cnt_r;
    logic qtick;
    assign qtick = pfd_tick_r && qdiv_r == QUARTER;
    always_ff @(posedge clk) begin
        if (srst || start_r)
            qdiv_r <= '0;
        else if (pfd_tick_r)
            qdiv_r <= qdiv_r + 2'h1;
    end
    always_ff @(posedge clk) begin
        if (srst)
            start_r <= 1'b0;
        else
            start_r <= wr_freq;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            aux_cnt_r <= '0;
            damp_cnt_r <= '0;
            pump_cnt_r <= '0;
        end else if (start_r) begin
            aux_cnt_r <= tmr_r.aux;
            damp_cnt_r <= tmr_r.damp;
            pump_cnt_r <= tmr_r.pump;
        end else if (qtick) begin
            if (aux_cnt_r != '0)
                aux_cnt_r <= aux_cnt_r - 9'h001;
            if (damp_cnt_r != '0)
                damp_cnt_r <= damp_cnt_r - 9'h001;
            if (pump_cnt_r != '0)
                pump_cnt_r <= pump_cnt_r - 9'h001;
        end
    end
    // Ramp uses one halving per quarter tick to avoid a current step
    logic [6:0] pump_r;
    always_ff @(posedge clk) begin
        if (srst)
            pump_r <= PUMP_UNITY;
        else if (start_r)
            pump_r <= PUMP_MAX;
        else if (qtick && pump_cnt_r == '0 && pump_r != PUMP_UNITY)
            pump_r <= pump_r >> 1;
    end

    // Digital lock detect: feedback edge near reference edge
    logic [3:0] age_r, good_r;
    logic locked_r;
    logic [3:0] thr;
    assign thr = (mode_r == MODE_LD10) ? 4'(LD_THR_HI_CYC)
        : 4'(LD_THR_LO_CYC);
    always_ff @(posedge clk) begin
        if (srst || hold_div) begin
            age_r <= 4'hF;
            good_r <= '0;
            locked_r <= 1'b0;
        end else begin
            if (pfd_tick_r)
                age_r <= '0;
            else if (age_r != 4'hF)
                age_r <= age_r + 4'h1;
            if (pfd_tick_r && good_r == LD_COUNT)
                locked_r <= 1'b1;
            if (fb_tick_r) begin
                if (age_r <= thr || pfd_tick_r) begin
                    if (good_r != LD_COUNT)
                        good_r <= good_r + 4'h1;
                end else begin
                    good_r <= '0;
                    locked_r <= 1'b0;
                end
            end
        end
    end

    // Registered outputs
    logic diag_nxt;
    always_comb begin
        case (mux_sel_r)
            MUX_LOCK: diag_nxt = locked_r;
            MUX_REFDIV: diag_nxt = ref_out_r;
            MUX_INTDIV: diag_nxt = int_out_r;
            MUX_TIMEOUT: diag_nxt = pump_cnt_r != '0;
            default: diag_nxt = 1'b0;
        endcase
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            aux_filter_switch <= 1'b0;
            damping_resistor_switches <= 1'b0;
            pump_current_scale <= PUMP_UNITY;
            pump_tristate <= 1'b1;
            amp_powerdown <= 1'b1;
            ref_buffer_en <= 1'b0;
            powered_up <= 1'b0;
            lock_detect <= 1'b0;
            diagnostic_output_pin <= 1'b0;
            feedback_ratio <= '0;
        end else begin
            aux_filter_switch <= aux_cnt_r != '0;
            damping_resistor_switches <= damp_cnt_r != '0;
            pump_current_scale <= pump_r;
            pump_tristate <= pwr.tristate | pwr.cp_pd;
            amp_powerdown <= pwr.amp_pd | ~up_r;
            ref_buffer_en <= ~pwr.cp_pd;
            powered_up <= up_r;
            lock_detect <= locked_r;
            diagnostic_output_pin <= diag_nxt;
            feedback_ratio <= nval_r;
        end
    end

    chk_pwr_route: assert property (@(posedge clk) disable iff (srst)
        wr_pwr |=> pwr_r == $past(shift_r[7:0]))
        else $error("power-down word not stored");
    chk_mode_route: assert property (@(posedge clk) disable iff (srst)
        wr_mode |=> mode_r == $past(shift_r[15:12]))
        else $error("mode word not stored");
    chk_timer_start: assert property (@(posedge clk) disable iff (srst)
        wr_freq |=> ##1 aux_cnt_r == tmr_r.aux && pump_r == PUMP_MAX)
        else $error("timers not restarted");
    chk_aux_switch: assert property (@(posedge clk) disable iff (srst)
        wr_freq && tmr_r.aux != '0 |=> ##2 aux_filter_switch)
        else $error("aux switch not closed");
    chk_damp_open: assert property (@(posedge clk) disable iff (srst)
        damp_cnt_r == '0 && !start_r |=> !damping_resistor_switches)
        else $error("damping switch not opened");
    chk_pump_ramp: assert property (@(posedge clk) disable iff (srst)
        qtick && !start_r && pump_cnt_r == '0 && pump_r != PUMP_UNITY
        |=> pump_r == $past(pump_r) >> 1)
        else $error("pump current not halved");
    chk_amp_pd: assert property (@(posedge clk) disable iff (srst)
        pwr_r[7] && pwr_r[6] |=> amp_powerdown)
        else $error("amplifier not powered down");
    chk_cp_pd: assert property (@(posedge clk) disable iff (srst)
        pwr_r[5] |=> pump_tristate && !ref_buffer_en && !locked_r)
        else $error("pump power-down incomplete");
    chk_div_hold: assert property (@(posedge clk) disable iff (srst)
        pwr_r[3] |=> ncnt_r == '0 && rcnt_r == '0)
        else $error("counters not held");
    chk_dbl_buf: assert property (@(posedge clk) disable iff (srst)
        wr_div && !wr_freq |=> div_act_r == $past(div_act_r))
        else $error("setup took effect early");
    chk_pwr_hold: assert property (@(posedge clk) disable iff (srst)
        !up_r |=> amp_powerdown && pump_tristate)
        else $error("active before init");
endmodule

/* File: fnfl_host_model.sv */
// Host side of the three-wire link: shifts words MSB first, then strobes.
// Assumes callers start on a clk falling edge; link clock period 400 ns.
module fnfl_host_model (
    output logic ser_clk,
    output logic ser_data,
    output logic load_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
    end
    // Data set while the clock is low; clock stands still between frames
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            #200 ser_clk = 1'b1;
            #200 ser_clk = 1'b0;
        end
        // Released data line shows the inverse, never a stale bit
        ser_data = ~w[0];
        #200 load_strobe = 1'b1;
        #400 load_strobe = 1'b0;
    endtask
endmodule

/* File: test_fnfl_core.sv */
// Self-checking bench for the fast-lock synthesizer core.
// Host model drives the link; bench drives reference and feedback pins.
module test_fnfl_core
    import fnfl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ref_in = 1'b0;
    logic rf_fb = 1'b0;
    logic follow = 1'b0;
    logic sclk, sdat, strobe, aux, damp, tri_s, amp, rbuf, pwr_up;
    logic lock, diag;
    logic [6:0] pump;
    logic [8:0] ratio;
    logic [31:0] lf = 32'hD664;
    logic [31:0] lm = 32'hD664;
    int err_total = 0;
    int total_checks = 0;
    int rt = 0;
    int rs = 0;

    fnfl_host_model host (.ser_clk(sclk), .ser_data(sdat),
        .load_strobe(strobe));
    fnfl_core dut (.clk(clk), .srst(srst), .ser_clk(sclk),
        .ser_data(sdat), .load_strobe(strobe), .reference_input(ref_in),
        .rf_feedback(rf_fb), .aux_filter_switch(aux),
        .damping_resistor_switches(damp), .pump_current_scale(pump),
        .pump_tristate(tri_s), .amp_powerdown(amp), .ref_buffer_en(rbuf),
        .powered_up(pwr_up), .lock_detect(lock),
        .diagnostic_output_pin(diag), .feedback_ratio(ratio));

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [8:0] e,
        input logic [8:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // Pin sampling and quarter-tick phase make timings inexact
    task automatic rng(input string nm, input int lo, input int hi,
        input logic signed [31:0] g);
        total_checks++;
        if ($isunknown(g) || g < lo || g > hi) begin
            err_total++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo,
                hi, g);
        end
    endtask

    task automatic wr(input logic [23:0] w);
        host.send(w);
        repeat (10) @(negedge clk);
    endtask

    task automatic wpwr(input logic [7:0] p);
        wr({16'h0000, p});
    endtask

    task automatic wmode(input logic [3:0] m, input logic [3:0] x);
        wr({8'h00, m, 5'h00, x, SEL_MODE});
    endtask

    // Which 0 watches pump scale, 1 watches the aux switch
    task automatic wait_ne(input int which, input logic [6:0] old);
        int n;
        logic [6:0] cur;
        n = 0;
        cur = old;
        while (cur === old) begin
            @(negedge clk);
            cur = (which == 1) ? {6'h00, aux} : pump;
            n++;
            if (n > 3000) begin
                err_total++;
                $display("wait limit reached");
                end_sim();
            end
        end
    endtask

    task automatic toggles(input int e);
        int n;
        logic p;
        n = 0;
        p = diag;
        repeat (128) begin
            @(negedge clk);
            if (diag !== p)
                n++;
            p = diag;
        end
        rng("diag_toggles", e - 1, e + 1, n);
    endtask

    initial begin
        forever #25 clk = ~clk;
    end

    // Reference period 400 ns; feedback pin random or a copy of it
    initial begin
        forever begin
            repeat (4) @(negedge clk);
            ref_in = ~ref_in;
            lf = nxt(lf);
            rf_fb = follow ? ref_in : lf[0];
        end
    end

    always @(posedge ref_in) rt++;
    always @(posedge strobe) rs = rt;

    initial begin
        logic [8:0] tp;
        logic [8:0] ts;
        logic [7:0] n;
        logic [11:0] f;
        logic signed [31:0] sum;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        chk("pump", 9'(PUMP_UNITY), 9'(pump));
        chk("tristate", 9'h001, 9'(tri_s));
        chk("powered_up", 9'h000, 9'(pwr_up));
        $display("test reset done");
        wpwr(PWR_RESET);
        chk("amp_pd", 9'h001, 9'(amp));
        wmode(MODE_DEFAULT, MUX_TIMEOUT);
        wmode(MODE_LD10, MUX_TIMEOUT);
        wmode(MODE_DITHER, MUX_TIMEOUT);
        wmode(MODE_DEFAULT, MUX_TIMEOUT);
        wr({9'h000, 12'h01A, SEL_PHASE});
        wr({5'h00, 4'h1, 12'h00D, SEL_DIV});
        wpwr(8'h05);
        chk("amp_pd", 9'h001, 9'(amp));
        chk("powered_up", 9'h000, 9'(pwr_up));
        for (int it = 0; it < 2; it++) begin
            lm = nxt(lm);
            tp = 9'h002 + 9'(lm[1:0]);
            ts = tp + 9'h007;
            n = 8'h40 + 8'(lm[7:2]);
            f = 12'h001 + 12'(lm[10:8]);
            wr({10'h001, ts, TSEL_DAMP, SEL_TIMER});
            wr({10'h001, ts, TSEL_AUX, SEL_TIMER});
            wr({10'h001, tp, TSEL_PUMP, SEL_TIMER});
            wr({1'b0, n, f, SEL_FREQ});
            chk("powered_up", 9'h001, 9'(pwr_up));
            chk("amp_pd", 9'h000, 9'(amp));
            chk("aux_sw", 9'h001, 9'(aux));
            chk("damp_sw", 9'h001, 9'(damp));
            chk("pump", 9'(PUMP_MAX), 9'(pump));
            chk("diag", 9'h001, 9'(diag));
            for (int k = 1; k <= 6; k++) begin
                wait_ne(0, pump);
                if (k == 1)
                    rng("pump_delay", 4 * tp - 4, 4 * tp + 8, rt - rs);
                chk("pump", 9'(PUMP_MAX >> k), 9'(pump));
            end
            chk("diag", 9'h000, 9'(diag));
            wait_ne(1, 7'h01);
            rng("aux_delay", 4 * ts - 4, 4 * ts + 8, rt - rs);
            chk("damp_sw", 9'h000, 9'(damp));
            sum = 0;
            repeat (13) begin
                @(posedge ref_in);
                repeat (6) @(negedge clk);
                sum += ratio;
            end
            rng("ratio_sum", 13 * n + f, 13 * n + f, sum);
            $display("test fast lock %0d done", it);
        end
        wmode(MODE_DEFAULT, MUX_REFDIV);
        toggles(16);
        wr({5'h00, 4'h2, 12'h00D, SEL_DIV});
        toggles(16);
        wr({1'b0, n, f, SEL_FREQ});
        toggles(8);
        wpwr(8'h0D);
        toggles(0);
        wpwr(8'h25);
        toggles(0);
        chk("tristate", 9'h001, 9'(tri_s));
        chk("ref_buf", 9'h000, 9'(rbuf));
        wpwr(8'h05);
        wr({1'b0, n, f, SEL_FREQ});
        chk("tristate", 9'h000, 9'(tri_s));
        chk("ref_buf", 9'h001, 9'(rbuf));
        toggles(8);
        wr({9'h000, 12'h000, SEL_PHASE});
        wr({5'h00, 4'h1, 12'h00D, SEL_DIV});
        wmode(MODE_LD10, MUX_LOCK);
        follow = 1'b1;
        // Integer one, no fraction: every feedback edge meets a reference tick
        wr({1'b0, 8'h01, 12'h000, SEL_FREQ});
        repeat (300) @(negedge clk);
        chk("lock", 9'h001, 9'(lock));
        chk("diag", 9'h001, 9'(diag));
        chk("ratio", 9'h001, ratio);
        wmode(MODE_DEFAULT, MUX_INTDIV);
        toggles(16);
        wpwr(8'h25);
        chk("lock", 9'h000, 9'(lock));
        follow = 1'b0;
        $display("test lock done");
        wpwr(8'h15);
        chk("tristate", 9'h001, 9'(tri_s));
        chk("ref_buf", 9'h001, 9'(rbuf));
        wpwr(8'hC7);
        wpwr(8'hC3);
        chk("amp_pd", 9'h000, 9'(amp));
        wpwr(8'hC5);
        chk("amp_pd", 9'h001, 9'(amp));
        $display("test power done");
        end_sim();
    end
endmodule
